// [vem_pkg.sv]
// Purpose: Shared constants for the video extent measurement block
// Assumes: Byte-wide register port, 16-bit register addresses
package vem_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int DIV_W = 8;
   localparam logic [15:0] ADDR_CTRL = 16'h8400;
   localparam logic [15:0] ADDR_OVR = 16'hFFF8;
   localparam logic [15:0] ADDR_INSEL = 16'hFFFD;
   localparam logic [15:0] ADDR_RES_BASE = 16'h8580;
   localparam logic [15:0] ADDR_RES_LAST = 16'h858F;
   localparam logic [15:0] ADDR_CFG = 16'h85A0;
   localparam logic [15:0] ADDR_DIV = 16'h85A1;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h85A2;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h85A3;
   localparam int CTRL_OSD_MASTER = 0;
   localparam int CTRL_WIN0 = 1;
   localparam int CTRL_WIN1 = 2;
   localparam int CTRL_START = 6;
   localparam int CTRL_DONE = 7;
   localparam int OVR_LO = 4;
   localparam int OVR_HI = 5;
   localparam int INSEL_BIT = 3;
   localparam int CFG_USE_SYNC = 0;
   localparam int CFG_HSYNC_INV = 1;
   localparam int CFG_VSYNC_INV = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FIELD = 1;
   localparam int IRQ_W = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] OVR_RESET = 8'h00;
   localparam logic [7:0] INSEL_RESET = 8'h08;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;
   localparam logic [CNT_W-1:0] PORCH_INIT = 16'hFFFF;
   typedef enum logic [1:0] {
      VEM_IDLE = 2'b00,
      VEM_ARM = 2'b01,
      VEM_RUN = 2'b10,
      VEM_DONE = 2'b11
   } vem_state_t;
endpackage

// [vem_axis_if.sv]
// Purpose: Carries one axis of reference, video and results
// Assumes: Driven by the top, served by one axis measurer
// Notes: One instance per horizontal and vertical axis
interface vem_axis_if #(parameter int CNT_W = 16);
   logic refLvl;
   logic videoLvl;
   logic unitTick;
   logic run;
   logic clear;
   logic [CNT_W-1:0] width;
   logic [CNT_W-1:0] backPorch;
   logic [CNT_W-1:0] frontPorch;
   logic refRise;
   modport meas(input refLvl, videoLvl, unitTick, run, clear,
      output width, backPorch, frontPorch, refRise);
   modport ctl(output refLvl, videoLvl, unitTick, run, clear,
      input width, backPorch, frontPorch, refRise);
endinterface

// [vem_tick_div.sv]
// Purpose: OSD pixel rate enable from the PLL pixel clock
// Assumes: Divisor of zero is treated as one
// Notes: Tick is a one-cycle pulse, held high every cycle when the divisor is zero or one
module vem_tick_div #(parameter int DIV_W = 8)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);
   logic [DIV_W-1:0] cnt_reg, cnt_next;
   if (DIV_W < 1)
   begin
      $error("DIV_W must be at least 1");
   end
   always_comb
   begin
      if (cnt_reg + DIV_W'(1) >= divisor)
      begin
         cnt_next = '0;
      end
      else
      begin
         cnt_next = cnt_reg + DIV_W'(1);
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_next;
      end
   end
   assign tick = (cnt_next == '0);
endmodule

// [vem_axis_meas.sv]
// Purpose: Width and shortest porches along one axis
// Assumes: Reference and video levels synchronous to clk
// Notes: Counts saturate; porch registers start at all ones
module vem_axis_meas #(parameter int CNT_W = 16)
(
   input wire logic clk,
   input wire logic reset,
   vem_axis_if.meas ax
);
   logic refD_reg, refD_next, vidD_reg, vidD_next;
   logic lookBack_reg, lookBack_next, vidSeen_reg, vidSeen_next;
   logic [CNT_W-1:0] wCnt_reg, wCnt_next, since_reg, since_next;
   logic [CNT_W-1:0] afterVid_reg, afterVid_next;
   logic [CNT_W-1:0] width_reg, width_next, back_reg, back_next;
   logic [CNT_W-1:0] front_reg, front_next;
   logic refRise, refFall, vidRise, vidFall;
   if (CNT_W < 2)
   begin
      $error("CNT_W must be at least 2");
   end
   function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
      satInc = (&v) ? v : v + CNT_W'(1);
   endfunction
   assign refRise = ax.refLvl & ~refD_reg;
   assign refFall = ~ax.refLvl & refD_reg;
   assign vidRise = ax.videoLvl & ~vidD_reg;
   assign vidFall = ~ax.videoLvl & vidD_reg;
   always_comb
   begin
      refD_next = ax.refLvl;
      vidD_next = ax.videoLvl;
      wCnt_next = wCnt_reg;
      since_next = since_reg;
      afterVid_next = afterVid_reg;
      lookBack_next = lookBack_reg;
      vidSeen_next = vidSeen_reg;
      width_next = width_reg;
      back_next = back_reg;
      front_next = front_reg;
      if (ax.unitTick)
      begin
         if (ax.refLvl)
         begin
            wCnt_next = satInc(wCnt_reg);
         end
         since_next = satInc(since_reg);
         afterVid_next = satInc(afterVid_reg);
      end
      if (refFall)
      begin
         if (ax.run)
         begin
            width_next = wCnt_reg;
         end
         since_next = '0;
         lookBack_next = 1'b1;
      end
      if (vidRise && lookBack_reg)
      begin
         lookBack_next = 1'b0;
         if (ax.run && since_reg < back_reg)
         begin
            back_next = since_reg;
         end
      end
      if (vidFall)
      begin
         afterVid_next = '0;
         vidSeen_next = 1'b1;
      end
      if (refRise)
      begin
         wCnt_next = '0;
         lookBack_next = 1'b0;
         vidSeen_next = 1'b0;
         if (ax.run && vidSeen_reg && afterVid_reg < front_reg)
         begin
            front_next = afterVid_reg;
         end
      end
      if (ax.clear)
      begin
         width_next = '0;
         back_next = '1;
         front_next = '1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         refD_reg <= 1'b0;
         vidD_reg <= 1'b0;
         wCnt_reg <= '0;
         since_reg <= '0;
         afterVid_reg <= '0;
         lookBack_reg <= 1'b0;
         vidSeen_reg <= 1'b0;
         width_reg <= '0;
         back_reg <= '1;
         front_reg <= '1;
      end
      else
      begin
         refD_reg <= refD_next;
         vidD_reg <= vidD_next;
         wCnt_reg <= wCnt_next;
         since_reg <= since_next;
         afterVid_reg <= afterVid_next;
         lookBack_reg <= lookBack_next;
         vidSeen_reg <= vidSeen_next;
         width_reg <= width_next;
         back_reg <= back_next;
         front_reg <= front_next;
      end
   end
   assign ax.width = width_reg;
   assign ax.backPorch = back_reg;
   assign ax.frontPorch = front_reg;
   assign ax.refRise = refRise;
endmodule

// [video_extent_measurement.sv]
// Purpose: Auto-size measurement of the incoming image extent
// Assumes: Video detect input is the above-threshold comparator output
// Notes: Horizontal in OSD pixels, vertical in lines
//
// Chosen here: the plain strobed port and the register addresses.
module video_extent_measurement
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [vem_pkg::ADDR_W-1:0] addr,
   input wire logic [vem_pkg::DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [vem_pkg::DATA_W-1:0] rdData,
   input wire logic hFlyback,
   input wire logic hSync,
   input wire logic vFlyback,
   input wire logic vSync,
   input wire logic videoDetect,
   output logic pllLockOverride,
   output logic hInputSelect,
   output logic osdMasterEnable,
   output logic [1:0] osdWindowEnable,
   output logic irq
);
   import vem_pkg::*;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] ovr_reg, ovr_next;
   logic [7:0] insel_reg, insel_next;
   logic [7:0] cfg_reg, cfg_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic [IRQ_W-1:0] stat_reg, stat_next, mask_reg, mask_next;
   logic [DATA_W-1:0] rd_reg, rd_next;
   logic done_reg, done_next;
   logic lineVid_reg, lineVid_next, lineVidOut_reg, lineVidOut_next;
   vem_state_t state_reg, state_next;
   logic hRef, vRef, pixTick, startPulse, fieldEvt, doneEvt;
   logic [IRQ_W-1:0] events;
   logic [CNT_W-1:0] results [0:5];
   logic [7:0] resByte [0:15];
   vem_axis_if #(.CNT_W(CNT_W)) hAx();
   vem_axis_if #(.CNT_W(CNT_W)) vAx();

   if (CNT_W != 16)
   begin
      $error("Result bytes assume 16-bit counts");
   end

   assign hRef = cfg_reg[CFG_USE_SYNC] ? (hSync ^ cfg_reg[CFG_HSYNC_INV]) : hFlyback;
   assign vRef = cfg_reg[CFG_USE_SYNC] ? (vSync ^ cfg_reg[CFG_VSYNC_INV]) : vFlyback;

   vem_tick_div #(.DIV_W(DIV_W)) pixDiv
   (
      .clk(clk),
      .reset(reset),
      .divisor(div_reg),
      .tick(pixTick)
   );

   vem_axis_meas #(.CNT_W(CNT_W)) hMeas
   (
      .clk(clk),
      .reset(reset),
      .ax(hAx.meas)
   );

   vem_axis_meas #(.CNT_W(CNT_W)) vMeas
   (
      .clk(clk),
      .reset(reset),
      .ax(vAx.meas)
   );

   // Horizontal axis counts OSD pixels against the PLL pixel clock
   assign hAx.refLvl = hRef;
   assign hAx.videoLvl = videoDetect;
   assign hAx.unitTick = pixTick;
   assign hAx.run = (state_reg == VEM_RUN);
   assign hAx.clear = startPulse;
   // Vertical axis counts lines; a line holds video if any was seen
   assign vAx.refLvl = vRef;
   assign vAx.videoLvl = lineVidOut_reg;
   assign vAx.unitTick = hAx.refRise;
   assign vAx.run = (state_reg == VEM_RUN);
   assign vAx.clear = startPulse;

   assign results[0] = hAx.width;
   assign results[1] = hAx.backPorch;
   assign results[2] = hAx.frontPorch;
   assign results[3] = vAx.width;
   assign results[4] = vAx.backPorch;
   assign results[5] = vAx.frontPorch;

   // Result bytes, low byte at even address, unused slots read zero
   for (genvar i = 0; i < 16; i++)
   begin
      if (i < 12)
      begin
         assign resByte[i] = results[i / 2][8 * (i % 2) +: 8];
      end
      else
      begin
         assign resByte[i] = 8'h00;
      end
   end

   assign startPulse = wrStrobe && addr == ADDR_CTRL && wrData[CTRL_START];
   assign fieldEvt = vAx.refRise;
   assign doneEvt = (state_reg == VEM_RUN) && fieldEvt;
   assign events = {fieldEvt, doneEvt};

   // Measurement sequencing and line video flag
   always_comb
   begin
      state_next = state_reg;
      done_next = done_reg;
      lineVid_next = lineVid_reg | videoDetect;
      lineVidOut_next = lineVidOut_reg;
      if (hAx.refRise)
      begin
         lineVidOut_next = lineVid_reg;
         lineVid_next = videoDetect;
      end
      unique case (state_reg)
         VEM_IDLE:
         begin
         end
         VEM_ARM:
         begin
            if (fieldEvt)
            begin
               state_next = VEM_RUN;
            end
         end
         VEM_RUN:
         begin
            if (fieldEvt)
            begin
               state_next = VEM_DONE;
               done_next = 1'b1;
            end
         end
         VEM_DONE:
         begin
         end
      endcase
      if (startPulse)
      begin
         state_next = VEM_ARM;
         done_next = 1'b0;
      end
   end

   // Register writes and read data
   always_comb
   begin
      ctrl_next = ctrl_reg;
      ovr_next = ovr_reg;
      insel_next = insel_reg;
      cfg_next = cfg_reg;
      div_next = div_reg;
      mask_next = mask_reg;
      rd_next = '0;
      if (wrStrobe)
      begin
         unique case (addr)
            ADDR_CTRL:
            begin
               ctrl_next = wrData;
            end
            ADDR_OVR:
            begin
               ovr_next = wrData;
            end
            ADDR_INSEL:
            begin
               insel_next = wrData;
            end
            ADDR_CFG:
            begin
               cfg_next = wrData;
            end
            ADDR_DIV:
            begin
               div_next = wrData;
            end
            ADDR_IRQ_MASK:
            begin
               mask_next = wrData[IRQ_W-1:0];
            end
            default:
            begin
            end
         endcase
      end
      if (rdStrobe)
      begin
         if (addr >= ADDR_RES_BASE && addr <= ADDR_RES_LAST)
         begin
            rd_next = resByte[addr[3:0]];
         end
         else
         begin
            unique case (addr)
               ADDR_CTRL:
               begin
                  rd_next = {done_reg, ctrl_reg[6:0]};
               end
               ADDR_OVR:
               begin
                  rd_next = ovr_reg;
               end
               ADDR_INSEL:
               begin
                  rd_next = insel_reg;
               end
               ADDR_CFG:
               begin
                  rd_next = cfg_reg;
               end
               ADDR_DIV:
               begin
                  rd_next = div_reg;
               end
               ADDR_IRQ_STAT:
               begin
                  rd_next = {6'h00, stat_reg};
               end
               ADDR_IRQ_MASK:
               begin
                  rd_next = {6'h00, mask_reg};
               end
               default:
               begin
                  rd_next = '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_reg <= CTRL_RESET;
         ovr_reg <= OVR_RESET;
         insel_reg <= INSEL_RESET;
         cfg_reg <= CFG_RESET;
         div_reg <= DIV_RESET;
         mask_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         ovr_reg <= ovr_next;
         insel_reg <= insel_next;
         cfg_reg <= cfg_next;
         div_reg <= div_next;
         mask_reg <= mask_next;
         rd_reg <= rd_next;
      end
   end

   // Sticky status, set wins over a clearing write
   always_comb
   begin
      stat_next = stat_reg;
      if (wrStrobe && addr == ADDR_IRQ_STAT)
      begin
         stat_next = stat_reg & ~wrData[IRQ_W-1:0];
      end
      stat_next = stat_next | events;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         stat_reg <= '0;
      end
      else
      begin
         stat_reg <= stat_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         done_reg <= 1'b0;
         lineVid_reg <= 1'b0;
         lineVidOut_reg <= 1'b0;
         state_reg <= VEM_IDLE;
      end
      else
      begin
         done_reg <= done_next;
         lineVid_reg <= lineVid_next;
         lineVidOut_reg <= lineVidOut_next;
         state_reg <= state_next;
      end
   end

   assign rdData = rd_reg;
   assign pllLockOverride = ovr_reg[OVR_HI] & ovr_reg[OVR_LO];
   assign hInputSelect = insel_reg[INSEL_BIT];
   assign osdMasterEnable = ctrl_reg[CTRL_OSD_MASTER];
   assign osdWindowEnable = {ctrl_reg[CTRL_WIN1], ctrl_reg[CTRL_WIN0]};
   assign irq = |(stat_reg & mask_reg);
endmodule

// [vem_asserts.sv]
// Purpose: Port checks of the video extent measurement block
// Assumes: Sees only the top module's ports
// Notes: Bound to the top module below
module vem_asserts
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [vem_pkg::ADDR_W-1:0] addr,
   input wire logic [vem_pkg::DATA_W-1:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   input wire logic [vem_pkg::DATA_W-1:0] rdData,
   input wire logic pllLockOverride,
   input wire logic hInputSelect,
   input wire logic osdMasterEnable,
   input wire logic [1:0] osdWindowEnable,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import vem_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_OVR_SET: assert property (wrStrobe && addr == ADDR_OVR |=>
      pllLockOverride == ($past(wrData[OVR_HI]) && $past(wrData[OVR_LO])))
      else $error("Override level wrong");
   AST_OVR_HOLD: assert property (!(wrStrobe && addr == ADDR_OVR) |=>
      $stable(pllLockOverride)) else $error("Override changed unasked");
   AST_INSEL_SET: assert property (wrStrobe && addr == ADDR_INSEL |=>
      hInputSelect == $past(wrData[INSEL_BIT])) else $error("Input select wrong");
   AST_CTRL_MASTER: assert property (wrStrobe && addr == ADDR_CTRL |=>
      osdMasterEnable == $past(wrData[CTRL_OSD_MASTER])) else $error("Master wrong");
   AST_CTRL_WIN: assert property (wrStrobe && addr == ADDR_CTRL |=>
      osdWindowEnable == $past(wrData[2:1])) else $error("Window enables wrong");
   AST_CTRL_HOLD: assert property (!(wrStrobe && addr == ADDR_CTRL) |=>
      $stable(osdWindowEnable)) else $error("Window enables changed unasked");
   AST_RD_IDLE: assert property (!rdStrobe |=> rdData == 8'h00)
      else $error("Read data outside read slot");
   AST_RES_PAD: assert property (rdStrobe && addr == ADDR_RES_LAST |=>
      rdData == 8'h00) else $error("Unused result byte not zero");
   AST_IRQ_MASK: assert property (wrStrobe && addr == ADDR_IRQ_MASK &&
      wrData == 8'h00 |=> !irq) else $error("Masked interrupt still high");
endmodule

bind video_extent_measurement vem_asserts chk_u (.clk(clk), .reset(reset), .addr(addr),
   .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
   .pllLockOverride(pllLockOverride), .hInputSelect(hInputSelect),
   .osdMasterEnable(osdMasterEnable), .osdWindowEnable(osdWindowEnable), .irq(irq));

// [vem_video_src.sv]
// Purpose: Video source model, 40 clocks a line, 13 lines a field
// Assumes: Reference pulses active high
// Notes: Line 7 has wider video to probe the shortest porches
module vem_video_src
(
   input wire logic clk,
   input wire logic reset,
   output logic hRef,
   output logic vRef,
   output logic video
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] pixReg;
   logic [3:0] lineReg;
   logic wide;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pixReg <= 6'h00;
         lineReg <= 4'h0;
      end
      else
      begin
         pixReg <= (pixReg == 6'h27) ? 6'h00 : pixReg + 6'h01;
         if (pixReg == 6'h27)
            lineReg <= (lineReg == 4'hC) ? 4'h0 : lineReg + 4'h1;
      end
   end
   assign wide = (lineReg == 4'h7);
   assign hRef = (pixReg < 6'h06);
   assign vRef = (lineReg < 4'h2);
   assign video = lineReg >= 4'h5 && lineReg <= 4'hA && pixReg >= (wide ? 6'h0D : 6'h10)
      && pixReg <= (wide ? 6'h22 : 6'h1F);
endmodule

// [testbench.sv]
// Purpose: Register level test of the video extent measurement block
// Assumes: Divisor one, except four in the last measurement pass
// Notes: Width and porch results allowed two units of slack
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import vem_pkg::*;
   logic clk, reset, wrStrobe, rdStrobe, useSync, hRef, vRef, video;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wrData, rdData, d, lo, hi;
   logic pllLockOverride, hInputSelect, osdMasterEnable, irq;
   logic [1:0] osdWindowEnable;
   logic [15:0] v, e;
   logic [15:0] expv [6] = '{16'h0006, 16'h0007, 16'h0005, 16'h0002, 16'h0003, 16'h0002};
   logic [7:0] osdSeq [4] = '{8'h01, 8'h07, 8'h01, 8'h00};
   int fails, n_tests;
   video_extent_measurement dut_u (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .hFlyback(hRef & ~useSync),
      .hSync(~hRef & useSync), .vFlyback(vRef & ~useSync), .vSync(~vRef & useSync),
      .videoDetect(video), .pllLockOverride(pllLockOverride), .hInputSelect(hInputSelect),
      .osdMasterEnable(osdMasterEnable), .osdWindowEnable(osdWindowEnable), .irq(irq));
   vem_video_src src_u (.clk(clk), .reset(reset), .hRef(hRef), .vRef(vRef), .video(video));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] w);
      @(posedge clk);
      addr <= a;
      wrData <= w;
      wrStrobe <= 1'b1;
      @(posedge clk);
      wrStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      @(posedge clk);
      addr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk);
      rdStrobe <= 1'b0;
      #1 q = rdData;
   endtask
   task automatic wait_done();
      logic [7:0] r = 8'h00;
      int n = 0;
      while (r[CTRL_DONE] !== 1'b1 && n < 1500)
      begin
         rd(ADDR_CTRL, r);
         n++;
      end
      if (r[CTRL_DONE] !== 1'b1)
      begin
         fails++;
         $display("Error at %0t: done never set", $time);
         stop_test();
      end
   endtask
   initial
   begin
      fails = 0;
      n_tests = 0;
      reset = 1'b1;
      addr = '0;
      wrData = '0;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      useSync = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(ADDR_CTRL, d); check(d, CTRL_RESET);
      rd(ADDR_OVR, d); check(d, OVR_RESET);
      rd(ADDR_INSEL, d); check(d, INSEL_RESET);
      rd(16'h1234, d); check(d, 16'h0000);
      check(hInputSelect, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_OVR, 8'(i << 4));
         #1 check(pllLockOverride, 16'(i == 3));
      end
      $display("Test registers done");
      for (int s = 0; s < 3; s++)
      begin
         @(posedge clk) useSync <= 1'(s == 1);
         wr(ADDR_CFG, (s == 1) ? 8'h07 : 8'h00);
         wr(ADDR_DIV, (s == 2) ? 8'h04 : 8'h01);
         wr(ADDR_IRQ_MASK, 8'h01);
         wr(ADDR_OVR, 8'h30);
         wr(ADDR_INSEL, 8'h00);
         wr(ADDR_CTRL, 8'h40);
         rd(ADDR_CTRL, d); check(d[CTRL_DONE], 1'b0);
         wait_done();
         check(irq, 1'b1);
         rd(ADDR_IRQ_STAT, d);
         check(d[IRQ_FIELD], 1'b1);
         for (int k = 0; k < 6; k++)
         begin
            rd(ADDR_RES_BASE + 16'(2 * k), lo);
            rd(ADDR_RES_BASE + 16'(2 * k + 1), hi);
            v = {hi, lo};
            e = (s == 2 && k < 3) ? expv[k] >> 2 : expv[k];
            check(v + 16'h0002 >= e && v <= e + 16'h0002, 1'b1);
         end
         rd(ADDR_RES_LAST, d); check(d, 16'h0000);
         repeat (600) @(posedge clk);
         rd(ADDR_CTRL, d); check(d[CTRL_DONE], 1'b1);
         rd(ADDR_RES_BASE + 16'h000A, lo);
         rd(ADDR_RES_BASE + 16'h000B, hi);
         check({hi, lo}, v);
         wr(ADDR_IRQ_MASK, 8'h00);
         wr(ADDR_IRQ_MASK, 8'h01);
         #1 check(irq, 1'b1);
         wr(ADDR_IRQ_STAT, 8'h01);
         @(posedge clk);
         #1 check(irq, 1'b0);
         wr(ADDR_INSEL, 8'h08);
         wr(ADDR_OVR, 8'h00);
         #1 check({hInputSelect, pllLockOverride}, 16'h0002);
         $display("Test measurement %0d done", s);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CTRL, osdSeq[i]);
         #1 check({osdWindowEnable, osdMasterEnable}, 16'(osdSeq[i][2:0]));
      end
      $display("Test osd done");
      stop_test();
   end
endmodule
